// ### tw_chk.sv
// port checks for the three-wire latch loader
// assumes it is bound to tw_latch_loader; all checks on the system clock
`timescale 1ns/1ps

module tw_chk
   import tw_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // inputs watched
   input wire logic chip_enable,
   input wire logic pump_up,
   input wire logic pump_dn,
   input wire tw_pkg::tw_observe_src_t observe_src,
   // outputs watched
   input wire logic charge_pump_output,
   input wire logic charge_pump_output_oe,
   input wire logic observe_output_pin,
   input wire tw_pkg::tw_latch_bank_t latches,
   input wire tw_pkg::tw_load_pulse_t load_pulse,
   input wire tw_pkg::tw_status_t status
);
   default clocking @(posedge clk); endclocking
   default disable iff (!nrst);

   function automatic logic pick(logic [2:0] c, tw_observe_src_t s);
      case (c)
         3'h1: return s.lock_detect;
         3'h2: return s.rf_div;
         3'h3: return s.ref_div;
         default: return 1'b0;
      endcase
   endfunction

   // ****
   // sequences
   // ****
   // long enough to cover two sync stages plus the output register
   sequence ce_low_s;
      !chip_enable [*5];
   endsequence
   sequence up_ok_s;
      (chip_enable && latches.ctrl[21:20] == 2'h0) [*5];
   endsequence
   sequence src_steady_s;
      ($stable(observe_src) && $stable(latches.ctrl)) [*5];
   endsequence
   sequence drive_s;
      (!status.powered_down && pump_up != pump_dn && $stable(pump_up)) [*3];
   endsequence

   // ****
   // assertions
   // ****
   pulse_onehot_a: assert property ($onehot0(load_pulse))
      else $error("more than one load pulse");
   ctrl_sel_a: assert property (!$stable(latches.ctrl) |-> load_pulse.load_ctrl)
      else $error("control word changed without its load");
   ref_sel_a: assert property (!$stable(latches.refdiv) |-> load_pulse.load_ref)
      else $error("reference word changed without its load");
   fb_sel_a: assert property (!$stable(latches.fbdiv) |-> load_pulse.load_fb)
      else $error("feedback word changed without its load");
   test_sel_a: assert property (!$stable(latches.test) |-> load_pulse.load_test)
      else $error("test word changed without its load");
   fb_bits_a: assert property (load_pulse.load_fb |-> latches.fbdiv[1:0] == SEL_FB)
      else $error("feedback word has wrong select bits");
   cp_off_a: assert property (ce_low_s |-> status.powered_down && !charge_pump_output_oe)
      else $error("pump driven while disabled");
   power_up_a: assert property (up_ok_s |-> !status.powered_down)
      else $error("still down with enable and clear bits");
   pd_bits_a: assert property ((latches.ctrl[21:20] != 2'h0) [*3] |-> status.powered_down)
      else $error("up although power-down bits set");
   cp_drive_a: assert property (drive_s |-> charge_pump_output_oe && charge_pump_output == pump_up)
      else $error("pump not driven as asked");
   mux_pin_a: assert property (src_steady_s |-> observe_output_pin == pick(latches.ctrl[7:5], observe_src))
      else $error("observe pin shows wrong source");
endmodule

bind tw_latch_loader tw_chk chk (
   .clk(clk), .nrst(nrst), .chip_enable(chip_enable), .pump_up(pump_up), .pump_dn(pump_dn),
   .observe_src(observe_src), .charge_pump_output(charge_pump_output),
   .charge_pump_output_oe(charge_pump_output_oe), .observe_output_pin(observe_output_pin),
   .latches(latches), .load_pulse(load_pulse), .status(status));

// ### tw_host.sv
// host model driving the serial load link
// assumes the bench calls send; the link clock runs only inside a frame
`timescale 1ns/1ps

module tw_host (
   // link pins
   output logic sclk,
   output logic sdata,
   output logic load_strobe
);
   initial begin
      sclk = 1'b0;
      sdata = 1'b0;
      load_strobe = 1'b0;
   end

   task automatic send(input logic [23:0] w, input logic ld);
      for (int i = 23; i >= 0; i--) begin
         sdata = w[i];
         #3 sclk = 1'b1;
         #3 sclk = 1'b0;
      end
      // a released data line must not keep the last bit
      sdata = ~w[0];
      // keeps the next frame's first bit out of this time step
      #3;
      if (ld) begin
         #10 load_strobe = 1'b1;
         #30 load_strobe = 1'b0;
         #20;
      end
   endtask
endmodule

// ### tw_latch_loader.sv
// three-wire serial load port with four word latches, power-down gating and observe pin
// assumes the host holds the serial clock still while the load strobe is high,
// so the shift register is quiet when the system clock side copies it
`timescale 1ns/1ps

module tw_latch_loader
   import tw_pkg::*;
(
   // system clock and reset
   input wire logic clk,
   input wire logic nrst,
   // serial link from the host
   input wire logic sclk,
   input wire logic sdata,
   input wire logic load_strobe,
   // chip enable pin
   input wire logic chip_enable,
   // charge pump drive from the phase detector
   input wire logic pump_up,
   input wire logic pump_dn,
   output logic charge_pump_output,
   output logic charge_pump_output_oe,
   // observe sources and pin
   input wire tw_pkg::tw_observe_src_t observe_src,
   output logic observe_output_pin,
   // programmed words and events
   output tw_pkg::tw_latch_bank_t latches,
   output tw_pkg::tw_load_pulse_t load_pulse,
   output logic band_select_start,
   output tw_pkg::tw_status_t status
);

   import tw_pkg::*;

   // ****************************************
   // serial clock domain
   // ****************************************
   logic [SR_W-1:0] shift_r;
   logic [CNT_W-1:0] bit_cnt_r;
   logic [CNT_W-1:0] bit_gray_r;
   logic [CNT_W-1:0] bit_cnt_nxt;

   assign bit_cnt_nxt = bit_cnt_r + 5'h01;

   always_ff @(posedge sclk or negedge nrst) begin
      if (!nrst) begin
         shift_r <= LATCH_RST;
      end else begin
         shift_r <= {shift_r[SR_W-2:0], sdata};
      end
   end

   // free-running bit count, handed over in gray code
   always_ff @(posedge sclk or negedge nrst) begin
      if (!nrst) begin
         bit_cnt_r <= '0;
         bit_gray_r <= '0;
      end else begin
         bit_cnt_r <= bit_cnt_nxt;
         bit_gray_r <= bit_cnt_nxt ^ (bit_cnt_nxt >> 1);
      end
   end

   // ****************************************
   // crossings into the system clock
   // ****************************************
   logic strobe_s;
   logic ce_s;
   logic [CNT_W-1:0] gray_s;
   tw_observe_src_t src_s;

   tw_sync #(.W(1)) u_sync_strobe (
      .clk(clk),
      .nrst(nrst),
      .d(load_strobe),
      .q(strobe_s)
   );

   tw_sync #(.W(1)) u_sync_ce (
      .clk(clk),
      .nrst(nrst),
      .d(chip_enable),
      .q(ce_s)
   );

   tw_sync #(.W(CNT_W)) u_sync_cnt (
      .clk(clk),
      .nrst(nrst),
      .d(bit_gray_r),
      .q(gray_s)
   );

   tw_sync #(.W(3)) u_sync_src (
      .clk(clk),
      .nrst(nrst),
      .d(observe_src),
      .q(src_s)
   );

   // ****************************************
   // load strobe edge and width
   // ****************************************
   logic strobe_d_r;
   logic load_now;
   logic strobe_fall;
   logic [WCNT_W-1:0] strobe_w_r;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         strobe_d_r <= 1'b0;
      end else begin
         strobe_d_r <= strobe_s;
      end
   end

   assign load_now = strobe_s & ~strobe_d_r;
   assign strobe_fall = ~strobe_s & strobe_d_r;

   // counts system clocks the strobe stays high, saturating at the least width
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         strobe_w_r <= '0;
      end else if (load_now) begin
         strobe_w_r <= 3'h1;
      end else if (strobe_s && strobe_w_r != T7_CYC_V) begin
         strobe_w_r <= strobe_w_r + 3'h1;
      end
   end

   // ****************************************
   // latch bank
   // ****************************************
   logic [SEL_W-1:0] sel;
   tw_load_pulse_t hit;

   assign sel = shift_r[SEL_W-1:0];

   always_comb begin
      hit = '0;
      unique case (sel)
         SEL_CTRL: hit.load_ctrl = load_now;
         SEL_REF: hit.load_ref = load_now;
         SEL_FB: hit.load_fb = load_now;
         SEL_TEST: hit.load_test = load_now;
      endcase
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         latches <= {4{LATCH_RST}};
      end else begin
         if (hit.load_ctrl) begin
            latches.ctrl <= shift_r;
         end
         if (hit.load_ref) begin
            latches.refdiv <= shift_r;
         end
         if (hit.load_fb) begin
            latches.fbdiv <= shift_r;
         end
         if (hit.load_test) begin
            latches.test <= shift_r;
         end
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         load_pulse <= '0;
         band_select_start <= 1'b0;
      end else begin
         load_pulse <= hit;
         // feedback divider update restarts band selection
         band_select_start <= hit.load_fb;
      end
   end

   // ****************************************
   // word length check
   // ****************************************
   logic [CNT_W-1:0] cnt_bin;
   logic [CNT_W-1:0] cnt_at_load_r;
   logic [CNT_W-1:0] bits_in_word;

   always_comb begin
      cnt_bin[CNT_W-1] = gray_s[CNT_W-1];
      for (int i = CNT_W - 2; i >= 0; i--) begin
         cnt_bin[i] = cnt_bin[i+1] ^ gray_s[i];
      end
   end

   // count wraps at 32, so a word of 24 plus a multiple of 32 bits is not caught
   assign bits_in_word = cnt_bin - cnt_at_load_r;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         cnt_at_load_r <= '0;
      end else if (load_now) begin
         cnt_at_load_r <= cnt_bin;
      end
   end

   // ****************************************
   // status flags, sticky until reset except powered_down, which follows chip enable and the power-down bits
   // ****************************************
   logic short_word_r, short_strobe_r, test_write_r, order_err_r, powered_down_r;
   assign status = {powered_down_r, short_word_r, short_strobe_r, test_write_r, order_err_r};

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         short_word_r <= 1'b0;
         short_strobe_r <= 1'b0;
         test_write_r <= 1'b0;
      end else begin
         if (load_now && bits_in_word != WORD_BITS) begin
            short_word_r <= 1'b1;
         end
         if (strobe_fall && strobe_w_r != T7_CYC_V) begin
            short_strobe_r <= 1'b1;
         end
         if (hit.load_test) begin
            test_write_r <= 1'b1;
         end
      end
   end

   // ****************************************
   // start-up load order
   // ****************************************
   tw_seq_t seq_r;
   logic any_other;

   assign any_other = hit.load_ctrl | hit.load_ref | hit.load_fb;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         seq_r <= TW_SEQ_WAIT_REF;
         order_err_r <= 1'b0;
      end else if (!ce_s) begin
         seq_r <= TW_SEQ_WAIT_REF;
      end else begin
         unique case (seq_r)
            TW_SEQ_WAIT_REF: begin
               if (hit.load_ref) begin
                  seq_r <= TW_SEQ_WAIT_CTRL;
               end else if (any_other) begin
                  order_err_r <= 1'b1;
               end
            end
            TW_SEQ_WAIT_CTRL: begin
               if (hit.load_ctrl) begin
                  seq_r <= TW_SEQ_WAIT_FB;
               end else if (any_other) begin
                  order_err_r <= 1'b1;
               end
            end
            TW_SEQ_WAIT_FB: begin
               if (hit.load_fb) begin
                  seq_r <= TW_SEQ_DONE;
               end else if (any_other) begin
                  order_err_r <= 1'b1;
               end
            end
            TW_SEQ_DONE: begin
               seq_r <= TW_SEQ_DONE;
            end
         endcase
      end
   end

   // ****************************************
   // power-down and charge pump
   // ****************************************
   logic pd_bits_set;
   logic powered_down_nxt;

   assign pd_bits_set = latches.ctrl[PD_LSB +: PD_W] != PD_NONE;
   assign powered_down_nxt = ~ce_s | pd_bits_set;

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         powered_down_r <= 1'b1;
      end else begin
         powered_down_r <= powered_down_nxt;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         charge_pump_output <= 1'b0;
         charge_pump_output_oe <= 1'b0;
      end else begin
         charge_pump_output <= pump_up & ~pump_dn;
         charge_pump_output_oe <= ~powered_down_nxt & (pump_up ^ pump_dn);
      end
   end

   // ****************************************
   // observe pin
   // ****************************************
   logic [MUX_W-1:0] mux_sel;
   logic observe_nxt;

   assign mux_sel = latches.ctrl[MUX_LSB +: MUX_W];

   always_comb begin
      observe_nxt = 1'b0;
      if (mux_sel == MUX_LOCK) begin
         observe_nxt = src_s.lock_detect;
      end else if (mux_sel == MUX_RF) begin
         observe_nxt = src_s.rf_div;
      end else if (mux_sel == MUX_REF) begin
         observe_nxt = src_s.ref_div;
      end else begin
         observe_nxt = 1'b0;
      end
   end

   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         observe_output_pin <= 1'b0;
      end else begin
         observe_output_pin <= observe_nxt;
      end
   end

endmodule

// ### tw_pkg.sv
// constants, types and field layout for the three-wire latch loader
// assumes a 200 mhz system clock and a host that drives serial clock, data and load strobe
//
// What this block does
// - every rising serial clock edge shifts the serial data level into the 24-bit shift register.
// - words travel most significant bit first and their two lowest bits are the latch select bits.
// - a rising load strobe copies the shift register into exactly one of four latches picked by those bits.
// - while chip enable is low the block is powered down and the charge pump output is not driven.
// - with chip enable high the block powers up only if the programmed power-down bits allow it.
// - the observe pin shows one chosen source: lock detect, divided feedback or divided reference.
// - select bits 00 pick control, 01 reference divider, 10 feedback divider, 11 test mode latch.
package tw_pkg;

   // ****************************************
   // word layout
   // ****************************************
   localparam int SR_W = 24;
   localparam int SEL_W = 2;
   localparam logic [SEL_W-1:0] SEL_CTRL = 2'h0;
   localparam logic [SEL_W-1:0] SEL_REF = 2'h1;
   localparam logic [SEL_W-1:0] SEL_FB = 2'h2;
   localparam logic [SEL_W-1:0] SEL_TEST = 2'h3;
   localparam logic [SR_W-1:0] LATCH_RST = 24'h000000;

   // control latch fields
   localparam int PD_LSB = 20;
   localparam int PD_W = 2;
   localparam int MUX_LSB = 5;
   localparam int MUX_W = 3;
   localparam logic [MUX_W-1:0] MUX_LOW = 3'h0;
   localparam logic [MUX_W-1:0] MUX_LOCK = 3'h1;
   localparam logic [MUX_W-1:0] MUX_RF = 3'h2;
   localparam logic [MUX_W-1:0] MUX_REF = 3'h3;
   localparam logic [PD_W-1:0] PD_NONE = 2'h0;

   // ****************************************
   // counters and timing
   // ****************************************
   localparam int CNT_W = 5;
   localparam logic [CNT_W-1:0] WORD_BITS = 5'h18;
   localparam int CLK_MHZ = 200;
   localparam int T7_NS = 20;
   // least time, rounded up
   localparam int T7_CYC = (T7_NS * CLK_MHZ + 999) / 1000;
   localparam int WCNT_W = 3;
   localparam logic [WCNT_W-1:0] T7_CYC_V = WCNT_W'(T7_CYC);

   // ****************************************
   // types
   // ****************************************
   typedef struct packed {
      logic [SR_W-1:0] ctrl;
      logic [SR_W-1:0] refdiv;
      logic [SR_W-1:0] fbdiv;
      logic [SR_W-1:0] test;
   } tw_latch_bank_t;

   typedef struct packed {
      logic powered_down;
      logic short_word;
      logic short_strobe;
      logic test_write;
      logic order_err;
   } tw_status_t;

   typedef struct packed {
      logic load_ctrl;
      logic load_ref;
      logic load_fb;
      logic load_test;
   } tw_load_pulse_t;

   typedef struct packed {
      logic lock_detect;
      logic rf_div;
      logic ref_div;
   } tw_observe_src_t;

   typedef enum logic [1:0] {
      TW_SEQ_WAIT_REF,
      TW_SEQ_WAIT_CTRL,
      TW_SEQ_WAIT_FB,
      TW_SEQ_DONE
   } tw_seq_t;

endpackage

// ### tw_sync.sv
// two flip-flop synchroniser, one stage pair per bit
// assumes the input is a level or a gray-coded word from another clock domain
`timescale 1ns/1ps

module tw_sync #(
   parameter int W = 1
) (
   // clock and reset
   input wire logic clk,
   input wire logic nrst,
   // data
   input wire logic [W-1:0] d,
   output logic [W-1:0] q
);

   logic [W-1:0] meta_r;

   // first stage feeds only the second stage
   always_ff @(posedge clk or negedge nrst) begin
      if (!nrst) begin
         meta_r <= '0;
         q <= '0;
      end else begin
         meta_r <= d;
         q <= meta_r;
      end
   end

endmodule

// ### tw_tb.sv
// self-checking bench for the three-wire latch loader
// assumes tw_host drives the link and tw_chk is bound to the design
`timescale 1ns/1ps

module tb_top;
   import tw_pkg::*;

   logic clk, nrst, chip_enable, pump_up, pump_dn;
   logic sclk, sdata, load_strobe;
   logic charge_pump_output, charge_pump_output_oe, observe_output_pin, band_select_start;
   tw_observe_src_t observe_src;
   tw_latch_bank_t latches;
   tw_load_pulse_t load_pulse;
   tw_status_t status;
   logic [23:0] bank [4];
   logic [31:0] rnd;
   int num_errors, n_compared;
   int n_bs = 0;
   int n_fb = 0;

   tw_latch_loader DUT (.clk(clk), .nrst(nrst), .sclk(sclk), .sdata(sdata),
      .load_strobe(load_strobe), .chip_enable(chip_enable), .pump_up(pump_up),
      .pump_dn(pump_dn), .charge_pump_output(charge_pump_output),
      .charge_pump_output_oe(charge_pump_output_oe), .observe_src(observe_src),
      .observe_output_pin(observe_output_pin), .latches(latches), .load_pulse(load_pulse),
      .band_select_start(band_select_start), .status(status));
   tw_host host (.sclk(sclk), .sdata(sdata), .load_strobe(load_strobe));

   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end

   // ****
   // helpers
   // ****
   function automatic logic [31:0] nx(input logic [31:0] s);
      return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
   endfunction
   // s is lock, rf, ref from high bit down
   function automatic logic exp_pin(input logic [2:0] c, input logic [2:0] s);
      return (c == 3'h1) ? s[2] : (c == 3'h2) ? s[1] : (c == 3'h3) ? s[0] : 1'b0;
   endfunction
   task automatic chk1(input logic got, input logic exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %0t bit %b want %b", $time, got, exp);
      end
   endtask
   task automatic chk24(input logic [23:0] got, input logic [23:0] exp);
      n_compared++;
      if (got !== exp) begin
         num_errors++;
         $display("unexpected %0t word %h want %h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input int got, input int exp);
      n_compared++;
      if (got != exp) begin
         num_errors++;
         $display("unexpected %0t count %0d want %0d", $time, got, exp);
      end
   endtask
   // every feedback load must restart band selection exactly once
   always @(negedge clk) begin
      if (band_select_start === 1'b1) begin
         n_bs++;
      end
   end
   task automatic idle(input int n);
      repeat (n) @(negedge clk);
   endtask
   task automatic ld(input logic [23:0] w);
      host.send(w, 1'b1);
      bank[w[1:0]] = w;
      if (w[1:0] == SEL_FB) begin
         n_fb++;
      end
      chk24(latches.ctrl, bank[0]);
      chk24(latches.refdiv, bank[1]);
      chk24(latches.fbdiv, bank[2]);
      chk24(latches.test, bank[3]);
   endtask
   task automatic conclude();
      if (num_errors == 0 && n_compared > 0) begin
         $display("TEST PASSED");
      end else begin
         $display("TEST FAILED");
      end
      $finish;
   endtask

   initial begin
      #200000;
      num_errors++;
      conclude();
   end

   // ****
   // main sequence
   // ****
   initial begin
      // a clean falling reset edge also clears the serial clock side, which sees no clk
      nrst = 1'b1;
      #1;
      nrst = 1'b0;
      chip_enable = 1'b0;
      pump_up = 1'b1;
      pump_dn = 1'b0;
      observe_src = '0;
      rnd = 32'h00000028;
      num_errors = 0;
      n_compared = 0;
      bank = '{default: LATCH_RST};
      idle(3);
      chk24(latches.ctrl, LATCH_RST);
      chk1(status.powered_down, 1'b1);
      nrst = 1'b1;
      chip_enable = 1'b1;
      // power-up order: reference, control, feedback
      ld(24'h000c81);
      ld(24'h000020);
      ld(24'h01f402);
      chk1(status.order_err, 1'b0);
      idle(6);
      chk1(status.powered_down, 1'b0);
      chk1(charge_pump_output_oe, 1'b1);
      chip_enable = 1'b0;
      idle(6);
      chk1(status.powered_down, 1'b1);
      chk1(charge_pump_output_oe, 1'b0);
      ld(24'h300000);
      @(negedge clk);
      chip_enable = 1'b1;
      idle(6);
      chk1(status.powered_down, 1'b1);
      ld(24'h000000);
      chk1(status.order_err, 1'b1);
      chk1(status.short_word, 1'b0);
      idle(6);
      chk1(status.powered_down, 1'b0);
      chk1(charge_pump_output, 1'b1);
      // every observe code, with sources that change
      for (int c = 0; c < 8; c++) begin
         ld({16'h0000, 3'(c), 5'h00});
         for (int k = 0; k < 3; k++) begin
            rnd = nx(rnd);
            @(negedge clk);
            observe_src = rnd[2:0];
            idle(5);
            chk1(observe_output_pin, exp_pin(3'(c), rnd[2:0]));
         end
      end
      // random words; some preceded by bits that must be shifted out
      for (int i = 0; i < 18; i++) begin
         rnd = nx(rnd);
         @(negedge clk);
         pump_up = rnd[24];
         pump_dn = rnd[25];
         if (i % 4 == 3) begin
            host.send(~rnd[23:0], 1'b0);
         end
         ld({rnd[23:2], 2'(i % 3)});
      end
      ld({rnd[31:10], SEL_TEST});
      chk1(status.test_write, 1'b1);
      chk1(status.short_word, 1'b1);
      chk1(status.short_strobe, 1'b0);
      chk_cnt(n_bs, n_fb);
      conclude();
   end
endmodule
